// >>> design/scic_pkg.sv
// Shared constants, register map and carrier types of the system clock and interrupt control
package scic_pkg;

	// ------------------------------------------------------------
	// Register byte offsets (HADDR[7:0])
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CLKCFG = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RIS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MIS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_IEN_SET = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IEN_CLR = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_ICR = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_GATING = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_SLP_EN = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_DSLP_EN = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_GPIO_HS = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_PWMDIV = 8'h2c;

	// ------------------------------------------------------------
	// Bus encodings
	// ------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ------------------------------------------------------------
	// Interrupt source bit positions
	// ------------------------------------------------------------
	localparam int NINT = 4;
	localparam int INT_BOR = 0;
	localparam int INT_PLL = 1;
	localparam int INT_USBPLL = 2;
	localparam int INT_MOSC = 3;
	localparam int HIB_BIT = 4;

	// ------------------------------------------------------------
	// Clock configuration word
	// ------------------------------------------------------------
	localparam int SYSDIV_W = 6;
	localparam int XTAL_W = 5;
	localparam int NPORTS = 8;
	// Ports A, B, C, E, F and H can move to the high-speed bus
	localparam logic [NPORTS-1:0] GPIO_HS_MASK = 8'hb7;
	localparam logic [SYSDIV_W-1:0] PWMDIV_RST = 6'h00;

	typedef enum logic [2:0] {
		OSC_MAIN = 3'h0,
		OSC_INT = 3'h1,
		OSC_INT4 = 3'h2,
		OSC_EXT32 = 3'h3,
		OSC_INT30 = 3'h4
	} scic_osc_e;

	typedef struct packed {
		logic main_osc_disable;
		logic internal_osc_disable;
		logic [XTAL_W-1:0] xtal;
		scic_osc_e osc;
		logic select_pll_source;
		logic [SYSDIV_W-1:0] sysclk_divide_setting;
	} scic_clkcfg_s;

	localparam int CLKCFG_W = $bits(scic_clkcfg_s);
	localparam scic_clkcfg_s CLKCFG_RST = '{1'b0, 1'b0, 5'h00, OSC_MAIN, 1'b0, 6'h00};

	typedef struct packed {
		logic valid;
		logic write;
		logic word;
		logic [ADDR_W-1:0] addr;
	} scic_aphase_s;

endpackage : scic_pkg

// >>> design/scic_clkdiv.sv
// Integer clock-enable divider whose ratio changes only at a period boundary
`timescale 1ns/10ps
module scic_clkdiv #(
	parameter int DIV_W = 6
) (
	input wire logic clk, // Source clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [DIV_W-1:0] div_val, // Requested ratio minus one
	output logic tick, // One-cycle enable per divided period
	output logic [DIV_W-1:0] cur // Ratio minus one now in force
);

	if (DIV_W < 1 || DIV_W > 16) begin : g_bad_w
		$error("scic_clkdiv: DIV_W out of range");
	end

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic [DIV_W-1:0] cur;
		logic tick;
	} scic_div_s;

	scic_div_s st_r;
	scic_div_s st_nxt;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// A new ratio is loaded only at wrap, so no period is ever cut short
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = (st_r.cnt == st_r.cur);
		if (st_r.cnt == st_r.cur) begin
			st_nxt.cnt = '0;
			st_nxt.cur = div_val;
		end else begin
			st_nxt.cnt = DIV_W'(st_r.cnt + 1'b1);
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
	assign cur = st_r.cur;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	cnt_range_a :
	assert property (@(posedge clk) disable iff (!rst_n) st_r.cnt <= st_r.cur)
		else $error("Divider count ran past its ratio");

	tick_period_a :
	assert property (@(posedge clk) disable iff (!rst_n)
		st_r.tick && (st_r.cur != '0) |=> !st_r.tick)
		else $error("Divided enable came early");

endmodule : scic_clkdiv

// >>> design/scic_sync.sv
// Three-flop synchroniser with rising-edge pulse for asynchronous status levels
`timescale 1ns/10ps
module scic_sync #(
	parameter int W = 5
) (
	input wire logic clk, // Local clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [W-1:0] async_in, // Levels from other domains
	output logic [W-1:0] level, // Synchronised level
	output logic [W-1:0] rise // One-cycle pulse on each rising edge
);

	if (W < 1) begin : g_bad_w
		$error("scic_sync: W must be positive");
	end

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] rise;
	} scic_sync_s;

	scic_sync_s st_r;
	scic_sync_s st_nxt;

	// ------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------
	// Only the second stage reads the first; edges are taken further down
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.rise = st_r.s2 & ~st_r.s3;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.s3;
	assign rise = st_r.rise;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	rise_pulse_a :
	assert property (@(posedge clk) disable iff (!rst_n) (st_r.rise != '0) |-> (st_r.rise & ~st_r.s3) == '0)
		else $error("Edge pulse without its level");

endmodule : scic_sync

// >>> design/scic_top.sv
// System clock selection, divider, oscillator gating, sleep clock policy and interrupt block
`timescale 1ns/10ps
// Behaviour
// - Processor clock is the selected source divided by a setting of 1 to 64.
// - One bit picks the PLL or the chosen oscillator directly as system clock.
// - Five oscillator choices: main, internal, internal/4, external 32 kHz, 30 kHz.
// - External 32 kHz choice accepted only with hibernation present and enabled.
// - Internal and main oscillators have separate disables; main stays on when used.
// - A disable aimed at the oscillator clocking the system is ignored.
// - PLL lock sets a raw status flag that software can poll.
// - Deep-sleep with gating runs only deep-sleep enabled peripherals; sleep with gating only sleep enabled ones; else all run.
// - A GPIO port without high-speed access is reached over the peripheral bus.
// - Ports A, B, C, E, F, H with high-speed access move to the fast bus.
// - A clear mask over the four sources deasserts each selected source.
// - Per-source enable and disable masks set or clear interrupt enable bits.
// - Processor interrupt is driven only by enabled, pending sources.
// - Peripherals use the processor clock except PWM, which has its own divider.
// - Software can read raw status and masked status.
// - Sleep enable sets apply only when peripheral clock gating is on.
module scic_top #(
	parameter int NPERIPH = 32,
	parameter bit HIB_PRESENT = 1'b1
) (
	input wire logic CLK, // System clock, 25 MHz
	input wire logic RESETN, // Asynchronous reset, active low
	input wire logic HSEL, // Slave select
	input wire logic [31:0] HADDR, // Byte address
	input wire logic [1:0] HTRANS, // Transfer type
	input wire logic HWRITE, // Write when high
	input wire logic [2:0] HSIZE, // Transfer size
	input wire logic [31:0] HWDATA, // Write data
	input wire logic HREADY, // Bus ready
	output logic [31:0] HRDATA, // Read data
	output logic HREADYOUT, // Slave ready
	output logic HRESP, // Always OKAY
	input wire logic PLL_LOCKED_IN, // PLL lock level, asynchronous
	input wire logic USBPLL_LOCKED_IN, // USB PLL lock level, asynchronous
	input wire logic MOSC_READY_IN, // Main oscillator powered up, asynchronous
	input wire logic BROWNOUT_IN, // Brown-out detect, asynchronous
	input wire logic HIB_ENABLED, // Hibernation unit enabled, asynchronous
	input wire logic SLEEP, // Processor in sleep
	input wire logic DEEP_SLEEP, // Processor in deep-sleep
	output logic [2:0] SYS_SRC, // Oscillator in force
	output logic SYS_USE_PLL, // PLL drives the system clock
	output logic [4:0] XTAL_SEL, // Crystal frequency setting to the PLL
	output logic MAIN_OSC_EN, // Main oscillator enable
	output logic INT_OSC_EN, // Internal oscillator enable
	output logic SYSCLK_EN, // Processor and peripheral clock enable
	output logic PWMCLK_EN, // PWM clock enable
	output logic [NPERIPH-1:0] PERIPH_CLK_EN, // Per-peripheral clock enable
	output logic [7:0] GPIO_HS_SEL, // Port uses the high-speed bus
	output logic IRQ // Processor interrupt, active high
);

	localparam int NSYNC = scic_pkg::NINT + 1;
	localparam int DW = scic_pkg::SYSDIV_W;

	if (NPERIPH < 1 || NPERIPH > 32) begin : g_bad_np
		$error("scic_top: NPERIPH must be 1 to 32");
	end

	typedef struct packed {
		scic_pkg::scic_aphase_s aph;
		logic hready;
		logic [31:0] hrdata;
		scic_pkg::scic_clkcfg_s cfg;
		scic_pkg::scic_osc_e act_src;
		logic act_pll;
		logic [DW-1:0] pwmdiv;
		logic [scic_pkg::NINT-1:0] ris;
		logic [scic_pkg::NINT-1:0] ien;
		logic gating;
		logic [NPERIPH-1:0] slp_en;
		logic [NPERIPH-1:0] dslp_en;
		logic [NPERIPH-1:0] periph_en;
		logic [scic_pkg::NPORTS-1:0] gpio_hs;
		logic irq;
		logic main_en;
		logic int_en;
	} scic_state_s;

	localparam scic_state_s ST_RST = '{
		aph: '0, hready: 1'b1, hrdata: '0, cfg: scic_pkg::CLKCFG_RST,
		act_src: scic_pkg::OSC_MAIN, act_pll: 1'b0, pwmdiv: scic_pkg::PWMDIV_RST,
		ris: '0, ien: '0, gating: 1'b0, slp_en: '1, dslp_en: '1, periph_en: '1,
		gpio_hs: '0, irq: 1'b0, main_en: 1'b1, int_en: 1'b1};

	scic_state_s st_r;
	scic_state_s st_nxt;
	logic [NSYNC-1:0] async_lvl;
	logic [NSYNC-1:0] sync_lvl;
	logic [NSYNC-1:0] sync_rise;
	logic [scic_pkg::NINT-1:0] ev_rise;
	logic [scic_pkg::NINT-1:0] clr_mask;
	logic sys_tick;
	logic pwm_tick;
	logic hib_ok;
	logic wr;
	logic [31:0] rdata;
	scic_pkg::scic_clkcfg_s new_cfg;
	scic_pkg::scic_clkcfg_s wr_cfg;

	// Write data seen as a clock word, kept apart so checks see the raw request
	assign wr_cfg = scic_pkg::scic_clkcfg_s'(HWDATA[scic_pkg::CLKCFG_W-1:0]);

	// ------------------------------------------------------------
	// Asynchronous status inputs
	// ------------------------------------------------------------
	assign async_lvl[scic_pkg::INT_BOR] = BROWNOUT_IN;
	assign async_lvl[scic_pkg::INT_PLL] = PLL_LOCKED_IN;
	assign async_lvl[scic_pkg::INT_USBPLL] = USBPLL_LOCKED_IN;
	assign async_lvl[scic_pkg::INT_MOSC] = MOSC_READY_IN;
	assign async_lvl[scic_pkg::HIB_BIT] = HIB_ENABLED;

	scic_sync #(.W(NSYNC)) u_sync (
		.clk(CLK),
		.rst_n(RESETN),
		.async_in(async_lvl),
		.level(sync_lvl),
		.rise(sync_rise)
	);

	assign ev_rise = sync_rise[scic_pkg::NINT-1:0];
	assign hib_ok = HIB_PRESENT && sync_lvl[scic_pkg::HIB_BIT];

	// ------------------------------------------------------------
	// Dividers
	// ------------------------------------------------------------
	// Processor and peripherals share one divider; PWM gets its own
	scic_clkdiv #(.DIV_W(DW)) u_sysdiv (
		.clk(CLK),
		.rst_n(RESETN),
		.div_val(st_r.cfg.sysclk_divide_setting),
		.tick(sys_tick),
		.cur()
	);

	scic_clkdiv #(.DIV_W(DW)) u_pwmdiv (
		.clk(CLK),
		.rst_n(RESETN),
		.div_val(st_r.pwmdiv),
		.tick(pwm_tick),
		.cur()
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		clr_mask = '0;
		rdata = '0;
		new_cfg = wr_cfg;
		wr = st_r.aph.valid && st_r.aph.write && st_r.aph.word;

		// Address phase; reads wait one cycle because the read data is registered
		st_nxt.aph.valid = HSEL && HREADY &&
			(HTRANS == scic_pkg::HTRANS_NONSEQ || HTRANS == scic_pkg::HTRANS_SEQ);
		st_nxt.aph.write = HWRITE;
		st_nxt.aph.word = (HSIZE == scic_pkg::HSIZE_WORD);
		st_nxt.aph.addr = HADDR[scic_pkg::ADDR_W-1:0];
		st_nxt.hready = !(st_nxt.aph.valid && !HWRITE);

		// Read decode; unmapped offsets read as zero
		if (st_r.aph.addr == scic_pkg::OFF_CLKCFG) begin
			rdata = 32'(st_r.cfg);
		end else if (st_r.aph.addr == scic_pkg::OFF_STATUS) begin
			rdata = 32'({st_r.main_en, st_r.int_en, sync_lvl[scic_pkg::HIB_BIT],
				st_r.act_pll, st_r.act_src, sync_lvl[scic_pkg::INT_PLL]});
		end else if (st_r.aph.addr == scic_pkg::OFF_RIS) begin
			rdata = 32'(st_r.ris);
		end else if (st_r.aph.addr == scic_pkg::OFF_MIS) begin
			rdata = 32'(st_r.ris & st_r.ien);
		end else if (st_r.aph.addr == scic_pkg::OFF_IEN_SET) begin
			rdata = 32'(st_r.ien);
		end else if (st_r.aph.addr == scic_pkg::OFF_GATING) begin
			rdata = 32'(st_r.gating);
		end else if (st_r.aph.addr == scic_pkg::OFF_SLP_EN) begin
			rdata = 32'(st_r.slp_en);
		end else if (st_r.aph.addr == scic_pkg::OFF_DSLP_EN) begin
			rdata = 32'(st_r.dslp_en);
		end else if (st_r.aph.addr == scic_pkg::OFF_GPIO_HS) begin
			rdata = 32'(st_r.gpio_hs);
		end else if (st_r.aph.addr == scic_pkg::OFF_PWMDIV) begin
			rdata = 32'(st_r.pwmdiv);
		end
		if (st_r.aph.valid && !st_r.aph.write) begin
			st_nxt.hrdata = rdata;
		end

		// Write decode; sub-word writes are dropped
		if (wr) begin
			if (st_r.aph.addr == scic_pkg::OFF_CLKCFG) begin
				// An unknown or unavailable source code keeps the old choice
				if (new_cfg.osc > scic_pkg::OSC_INT30 ||
					(new_cfg.osc == scic_pkg::OSC_EXT32 && !hib_ok)) begin
					new_cfg.osc = st_r.cfg.osc;
				end
				st_nxt.cfg = new_cfg;
			end else if (st_r.aph.addr == scic_pkg::OFF_IEN_SET) begin
				st_nxt.ien = st_r.ien | HWDATA[scic_pkg::NINT-1:0];
			end else if (st_r.aph.addr == scic_pkg::OFF_IEN_CLR) begin
				st_nxt.ien = st_r.ien & ~HWDATA[scic_pkg::NINT-1:0];
			end else if (st_r.aph.addr == scic_pkg::OFF_ICR) begin
				clr_mask = HWDATA[scic_pkg::NINT-1:0];
			end else if (st_r.aph.addr == scic_pkg::OFF_GATING) begin
				st_nxt.gating = HWDATA[0];
			end else if (st_r.aph.addr == scic_pkg::OFF_SLP_EN) begin
				st_nxt.slp_en = HWDATA[NPERIPH-1:0];
			end else if (st_r.aph.addr == scic_pkg::OFF_DSLP_EN) begin
				st_nxt.dslp_en = HWDATA[NPERIPH-1:0];
			end else if (st_r.aph.addr == scic_pkg::OFF_GPIO_HS) begin
				st_nxt.gpio_hs = HWDATA[scic_pkg::NPORTS-1:0] & scic_pkg::GPIO_HS_MASK;
			end else if (st_r.aph.addr == scic_pkg::OFF_PWMDIV) begin
				st_nxt.pwmdiv = HWDATA[DW-1:0];
			end
		end

		// Sticky raw status; a new event beats a clear in the same cycle
		st_nxt.ris = (st_r.ris & ~clr_mask) | ev_rise;
		st_nxt.irq = |(st_r.ris & st_r.ien);

		// Source switches only at a divided-period boundary
		if (sys_tick) begin
			st_nxt.act_src = st_r.cfg.osc;
			st_nxt.act_pll = st_r.cfg.select_pll_source;
		end

		// An oscillator in use, or about to be, cannot be switched off
		st_nxt.main_en = !st_r.cfg.main_osc_disable ||
			st_r.act_src == scic_pkg::OSC_MAIN || st_r.cfg.osc == scic_pkg::OSC_MAIN;
		st_nxt.int_en = !st_r.cfg.internal_osc_disable ||
			st_r.act_src == scic_pkg::OSC_INT || st_r.act_src == scic_pkg::OSC_INT4 ||
			st_r.cfg.osc == scic_pkg::OSC_INT || st_r.cfg.osc == scic_pkg::OSC_INT4;

		// Sleep enable sets count only with gating on; otherwise run-mode clocking
		if (DEEP_SLEEP && st_r.gating) begin
			st_nxt.periph_en = st_r.dslp_en;
		end else if (SLEEP && st_r.gating) begin
			st_nxt.periph_en = st_r.slp_en;
		end else begin
			st_nxt.periph_en = '1;
		end
	end

	// State register
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign HRDATA = st_r.hrdata;
	assign HREADYOUT = st_r.hready;
	assign HRESP = 1'b0;
	assign SYS_SRC = st_r.act_src;
	assign SYS_USE_PLL = st_r.act_pll;
	assign XTAL_SEL = st_r.cfg.xtal;
	assign MAIN_OSC_EN = st_r.main_en;
	assign INT_OSC_EN = st_r.int_en;
	assign SYSCLK_EN = sys_tick;
	assign PWMCLK_EN = pwm_tick;
	assign PERIPH_CLK_EN = st_r.periph_en;
	assign GPIO_HS_SEL = st_r.gpio_hs;
	assign IRQ = st_r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	src_boundary_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		(st_r.act_src != $past(st_r.act_src)) |-> $past(sys_tick))
		else $error("Source changed away from a period boundary");

	ext32_guard_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		wr && st_r.aph.addr == scic_pkg::OFF_CLKCFG && !hib_ok &&
		wr_cfg.osc == scic_pkg::OSC_EXT32 && st_r.cfg.osc != scic_pkg::OSC_EXT32
		|=> st_r.cfg.osc != scic_pkg::OSC_EXT32)
		else $error("External 32k accepted without hibernation");

	main_inuse_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		(st_r.act_src == scic_pkg::OSC_MAIN) [*2] |-> MAIN_OSC_EN)
		else $error("Main oscillator off while in use");

	int_inuse_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		(st_r.act_src == scic_pkg::OSC_INT || st_r.act_src == scic_pkg::OSC_INT4) [*2]
		|-> INT_OSC_EN)
		else $error("Internal oscillator off while in use");

	pll_flag_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		ev_rise[scic_pkg::INT_PLL] |=> st_r.ris[scic_pkg::INT_PLL])
		else $error("PLL lock flag not set");

	ris_sticky_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		1'b1 |=> (($past(st_r.ris) & ~$past(clr_mask)) & ~st_r.ris) == '0)
		else $error("Raw status bit lost without a clear");

	clear_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		1'b1 |=> (($past(clr_mask) & ~$past(ev_rise)) & st_r.ris) == '0)
		else $error("Cleared source still pending");

	irq_mask_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		(st_r.ris & st_r.ien) == '0 ##1 (st_r.ris & st_r.ien) == '0 |-> !IRQ)
		else $error("Interrupt raised by a disabled source");

	gating_off_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		!st_r.gating |=> PERIPH_CLK_EN == '1)
		else $error("Peripheral clocks gated with gating off");

	gpio_hs_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		(GPIO_HS_SEL & ~scic_pkg::GPIO_HS_MASK) == '0)
		else $error("Port without fast-bus option moved");

	read_wait_a :
	assert property (@(posedge CLK) disable iff (!RESETN)
		st_r.aph.valid && !st_r.aph.write |-> !HREADYOUT ##1 HREADYOUT)
		else $error("Read answer not one wait state");

endmodule : scic_top

// >>> dv/tb_scic_top.sv
// Self-checking bench for the system clock and interrupt control block
`timescale 1ns/10ps
module tb_scic_top;
	// ----------------------------------------
	// Stimulus state
	// ----------------------------------------
	logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hib = 1'b0;
	logic slp = 1'b0, dslp = 1'b0, hreadyout, hresp, use_pll, mosc_en, iosc_en;
	logic sys_en, pwm_en, irq;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, periph;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, src;
	logic [4:0] xtal;
	logic [7:0] hs_sel;
	logic [3:0] ev = 4'h0; // Brownout, PLL, USB PLL, main osc levels
	int error_cnt = 0, samples_checked = 0, cyc = 0, n1, n2;
	// Register rows: offset, value written, value read back
	logic [7:0] ra[8] = '{8'h00, 8'h1c, 8'h28, 8'h2c, 8'h24, 8'h20, 8'h40, 8'h08};
	logic [31:0] rw[8] = '{32'h83, '1, '1, '1, 32'ha5, 32'h5a, '1, 32'hf};
	logic [31:0] rx[8] = '{32'h83, 32'h1, 32'hb7, 32'h3f, 32'ha5, 32'h5a, 32'h0, 32'h0};

	// Free-running clock, 40 ns period
	always #20 clk = ~clk;

	scic_top u_scic_top (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.PLL_LOCKED_IN(ev[1]), .USBPLL_LOCKED_IN(ev[2]), .MOSC_READY_IN(ev[3]),
		.BROWNOUT_IN(ev[0]), .HIB_ENABLED(hib), .SLEEP(slp), .DEEP_SLEEP(dslp),
		.SYS_SRC(src), .SYS_USE_PLL(use_pll), .XTAL_SEL(xtal), .MAIN_OSC_EN(mosc_en),
		.INT_OSC_EN(iosc_en), .SYSCLK_EN(sys_en), .PWMCLK_EN(pwm_en),
		.PERIPH_CLK_EN(periph), .GPIO_HS_SEL(hs_sel), .IRQ(irq));

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// Waits end on a falling edge, where registered outputs have settled
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w

	// Single word transfer; ready is looked at half a cycle before the edge that samples it
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do begin
			@(negedge clk);
		end while (hreadyout !== 1'b1);
		@(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(negedge clk);
			q = hrdata;
		end while (hreadyout !== 1'b1);
		@(posedge clk);
		hsel <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd

	// Hang guard, well above the expected run of a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc >= 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		w(8);
		@(posedge clk) resetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h20, 32'hffffffff);
		chk({mosc_en, iosc_en, irq}, 3'h6);
		// Ordinary register rows, read-only and unmapped places among them
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, ra[i], rw[i]);
			rd(ra[i], rx[i]);
		end
		w(10);
		chk(hs_sel, 8'hb7);
		chk(src, 3'h1);
		// Divide by 4 and PWM divide by 64 over a 128-cycle window
		n1 = 0;
		n2 = 0;
		repeat (128) begin
			@(negedge clk);
			n1 += int'(sys_en === 1'b1);
			n2 += int'(pwm_en === 1'b1);
		end
		chk(n1, 32);
		chk(n2, 2);
		bus(1'b1, 8'h28, 32'h0);
		w(3);
		chk(hs_sel, 8'h0);
		// Every oscillator code; external 32k refused while hibernation is off
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, 8'h00, k << 7);
			w(6);
			chk(src, (k == 3) ? 3'h2 : k);
		end
		@(posedge clk) hib <= 1'b1;
		// Let the enable level cross the synchroniser before asking for the 32k choice
		w(4);
		bus(1'b1, 8'h00, 32'h3 << 7);
		w(6);
		chk(src, 3'h3);
		bus(1'b1, 8'h00, 32'h2c40);
		w(6);
		chk(use_pll, 1'b1);
		chk(xtal, 5'hb);
		// Both disables set: the oscillator in use stays on
		bus(1'b1, 8'h00, 32'h18080);
		w(6);
		chk({iosc_en, mosc_en}, 2'h2);
		bus(1'b1, 8'h00, 32'h18000);
		w(6);
		chk({iosc_en, mosc_en}, 2'h1);
		rd(8'h04, 32'ha0);
		// Events latch with no enable and keep the interrupt quiet
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) ev[i] <= 1'b1;
			w(8);
			rd(8'h08, (32'h2 << i) - 1);
			chk(irq, 1'b0);
		end
		rd(8'h04, 32'ha1);
		bus(1'b1, 8'h10, 32'h2);
		w(3);
		chk(irq, 1'b1);
		rd(8'h0c, 32'h2);
		bus(1'b1, 8'h14, 32'h2);
		w(3);
		chk(irq, 1'b0);
		rd(8'h08, 32'hf);
		bus(1'b1, 8'h18, 32'h5);
		rd(8'h08, 32'ha);
		// Sleep policy with gating on, then off
		bus(1'b1, 8'h1c, 32'h1);
		@(posedge clk) dslp <= 1'b1;
		w(3);
		chk(periph, 32'ha5);
		@(posedge clk) begin
			dslp <= 1'b0;
			slp <= 1'b1;
		end
		w(3);
		chk(periph, 32'h5a);
		bus(1'b1, 8'h1c, 32'h0);
		w(3);
		chk(periph, 32'hffffffff);
		// Sub-word writes are dropped
		@(posedge clk) hsize <= 3'h0;
		bus(1'b1, 8'h1c, 32'h1);
		@(posedge clk) hsize <= 3'h2;
		rd(8'h1c, 32'h0);
		// Reset in mid-run restores register defaults
		@(posedge clk) resetn <= 1'b0;
		w(3);
		chk({src, irq, mosc_en}, 5'h1);
		chk({hreadyout, hresp}, 2'h2);
		@(posedge clk) resetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h24, 32'hffffffff);
		complete_run();
	end
endmodule : tb_scic_top
